//--- hdl/cwpr_pkg.sv
/*
  Shared constants, field layout, timing counts and level tables for the
  channel-two voltage result and overload protection registers.
  Assumes a 10 MHz system clock; all counts are derived from that rate.
*/
package cwpr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_VOLTAGE_RESULT = 8'h1b;
  localparam logic [7:0] ADDR_PROTECT_CFG = 8'h1c;

  // Values after reset
  localparam logic [15:0] VOLTAGE_RESULT_RESET = 16'h0000;
  localparam logic [15:0] PROTECT_CFG_RESET = 16'h0000;

  // Voltage result layout
  localparam int RESULT_WIDTH = 10;
  localparam int FRESH_BIT = 10;

  // Protection configuration layout
  localparam int COOLDOWN_LSB = 14;
  localparam int DELAY_LSB = 9;
  localparam int THRESHOLD_LSB = 7;
  localparam int TRIP_LSB = 3;
  localparam int NOMINAL_LSB = 0;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hc7ff;
  localparam logic [1:0] COOLDOWN_LATCH = 2'h0;

  // Clock rate
  localparam int CLK_KHZ = 10000;

  // Delayed turn-off times in microseconds
  localparam int DELAY_US_0 = 200;
  localparam int DELAY_US_1 = 400;
  localparam int DELAY_US_2 = 1000;
  localparam int DELAY_US_3 = 2000;
  localparam int DELAY_CYCLES_0 = DELAY_US_0 * CLK_KHZ / 1000;
  localparam int DELAY_CYCLES_1 = DELAY_US_1 * CLK_KHZ / 1000;
  localparam int DELAY_CYCLES_2 = DELAY_US_2 * CLK_KHZ / 1000;
  localparam int DELAY_CYCLES_3 = DELAY_US_3 * CLK_KHZ / 1000;

  // Cool-down times in milliseconds
  localparam int COOLDOWN_MS_1 = 800;
  localparam int COOLDOWN_MS_2 = 2000;
  localparam int COOLDOWN_MS_3 = 4000;
  localparam int COOLDOWN_CYCLES_1 = COOLDOWN_MS_1 * CLK_KHZ;
  localparam int COOLDOWN_CYCLES_2 = COOLDOWN_MS_2 * CLK_KHZ;
  localparam int COOLDOWN_CYCLES_3 = COOLDOWN_MS_3 * CLK_KHZ;

  // Width of the countdown timers
  localparam int TIMER_WIDTH = 26;

  // Protection sequencer states
  typedef enum logic [3:0] {
    ST_ON = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_COOLDOWN = 4'b0100,
    ST_LATCHED = 4'b1000
  } cwpr_fsm_type;

  // Delayed turn-off threshold in hundredths
  function automatic logic [15:0] threshold_level(input logic [1:0] code);
    case (code)
      2'h0: threshold_level = 16'd1955;
      2'h1: threshold_level = 16'd1760;
      2'h2: threshold_level = 16'd1605;
      default: threshold_level = 16'd1330;
    endcase
  endfunction

  // Energy trip level in tenths of A2s
  function automatic logic [11:0] trip_level(input logic [3:0] code);
    case (code)
      4'h0: trip_level = 12'd88;
      4'h1: trip_level = 12'd131;
      4'h2: trip_level = 12'd263;
      4'h3: trip_level = 12'd394;
      4'h4: trip_level = 12'd525;
      4'h5: trip_level = 12'd656;
      4'h6: trip_level = 12'd788;
      4'h7: trip_level = 12'd919;
      4'h8: trip_level = 12'd1094;
      4'h9: trip_level = 12'd1269;
      4'ha: trip_level = 12'd1444;
      4'hb: trip_level = 12'd1663;
      4'hc: trip_level = 12'd1925;
      4'hd: trip_level = 12'd2188;
      4'he: trip_level = 12'd2625;
      default: trip_level = 12'd3500;
    endcase
  endfunction

  // Nominal current in tenths of an ampere
  function automatic logic [7:0] nominal_level(input logic [2:0] code);
    case (code)
      3'h0: nominal_level = 8'd40;
      3'h1: nominal_level = 8'd50;
      3'h2: nominal_level = 8'd57;
      3'h3: nominal_level = 8'd65;
      3'h4: nominal_level = 8'd75;
      3'h5: nominal_level = 8'd90;
      3'h6: nominal_level = 8'd120;
      default: nominal_level = 8'd150;
    endcase
  endfunction

endpackage

//--- hdl/cwpr_result_capture.sv
/*
  Holds the latest output-voltage conversion and a flag that marks it as
  not yet read. Assumes sample and read strobes are on the same clock.
*/
module cwpr_result_capture (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Conversion input
  input wire logic sample_valid_i,
  input wire logic [cwpr_pkg::RESULT_WIDTH-1:0] sample_i,
  // Host read strobe
  input wire logic read_i,
  // Held result
  output logic [cwpr_pkg::RESULT_WIDTH-1:0] value_o,
  output logic fresh_o
);
  import cwpr_pkg::*;

  typedef struct packed {
    logic [RESULT_WIDTH-1:0] value;
    logic fresh;
  } cwpr_capture_type;

  cwpr_capture_type state;
  cwpr_capture_type next_state;

  // New sample wins over a read in the same cycle
  always_comb
  begin
    next_state = state;
    if (sample_valid_i)
    begin
      next_state.value = sample_i;
      next_state.fresh = 1'b1;
    end
    else if (read_i)
    begin
      next_state.fresh = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign value_o = state.value;
  assign fresh_o = state.fresh;

endmodule

//--- hdl/cwpr_timer.sv
/*
  One-shot countdown timer: a start pulse loads a length in cycles and the
  done flag rises after exactly that many clock edges. Assumes length >= 1.
*/
module cwpr_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [cwpr_pkg::TIMER_WIDTH-1:0] length_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  import cwpr_pkg::*;

  typedef struct packed {
    logic [TIMER_WIDTH-1:0] count;
    logic busy;
  } cwpr_timer_type;

  cwpr_timer_type state;
  cwpr_timer_type next_state;

  // Load, count down, stop at zero
  always_comb
  begin
    next_state = state;
    if (start_i)
    begin
      next_state.count = length_i - TIMER_WIDTH'(1);
      next_state.busy = 1'b1;
    end
    else if (abort_i || (state.busy && state.count == '0))
    begin
      next_state.busy = 1'b0;
    end
    else if (state.busy)
    begin
      next_state.count = state.count - TIMER_WIDTH'(1);
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign busy_o = state.busy;
  assign done_o = state.busy && (state.count == '0);

endmodule

//--- hdl/cwpr_regs.sv
/*
  Channel-two voltage result register and overload protection register,
  with the delayed turn-off and cool-down sequencer that they steer.
  Assumes a decoded register port from the serial interface, and conversion,
  comparator and energy-trip strobes from logic on the same 10 MHz clock.
  Trip and overcurrent events that arrive while the channel is forced off are ignored.
*/
module cwpr_regs #(
  parameter int unsigned DELAY_CYCLES_0 = cwpr_pkg::DELAY_CYCLES_0,
  parameter int unsigned DELAY_CYCLES_1 = cwpr_pkg::DELAY_CYCLES_1,
  parameter int unsigned DELAY_CYCLES_2 = cwpr_pkg::DELAY_CYCLES_2,
  parameter int unsigned DELAY_CYCLES_3 = cwpr_pkg::DELAY_CYCLES_3,
  parameter int unsigned COOLDOWN_CYCLES_1 = cwpr_pkg::COOLDOWN_CYCLES_1,
  parameter int unsigned COOLDOWN_CYCLES_2 = cwpr_pkg::COOLDOWN_CYCLES_2,
  parameter int unsigned COOLDOWN_CYCLES_3 = cwpr_pkg::COOLDOWN_CYCLES_3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Conversion input
  input wire logic adc_valid_i,
  input wire logic [cwpr_pkg::RESULT_WIDTH-1:0] adc_data_i,
  // Protection events
  input wire logic over_threshold_i,
  input wire logic energy_trip_i,
  input wire logic restart_i,
  // Channel state
  output logic channel_shutdown_o,
  output logic latched_off_o,
  // Decoded settings for the protection datapath
  output logic [15:0] delayed_off_threshold_ch2_o,
  output logic [11:0] energy_trip_level_ch2_o,
  output logic [7:0] nominal_current_ch2_o
);
  import cwpr_pkg::*;

  typedef struct packed {
    logic [15:0] cfg;
    cwpr_fsm_type fsm;
    logic [15:0] rdata;
    logic shutdown;
    logic latched;
    logic [15:0] threshold;
    logic [11:0] trip;
    logic [7:0] nominal;
  } cwpr_regs_type;

  cwpr_regs_type state;
  cwpr_regs_type next_state;

  logic [RESULT_WIDTH-1:0] voltage_result_value_ch2;
  logic voltage_result_fresh_ch2;
  logic result_read;
  logic delay_start;
  logic delay_abort;
  logic delay_done;
  logic cooldown_start;
  logic cooldown_done;
  logic fault;
  logic [1:0] cooldown_select_ch2;
  logic [1:0] delayed_off_time_ch2;
  logic [TIMER_WIDTH-1:0] delay_length;
  logic [TIMER_WIDTH-1:0] cooldown_length;

  // Cycle count for a delayed turn-off code
  function automatic logic [TIMER_WIDTH-1:0] delay_cycles(input logic [1:0] code);
    case (code)
      2'h0: delay_cycles = TIMER_WIDTH'(DELAY_CYCLES_0);
      2'h1: delay_cycles = TIMER_WIDTH'(DELAY_CYCLES_1);
      2'h2: delay_cycles = TIMER_WIDTH'(DELAY_CYCLES_2);
      default: delay_cycles = TIMER_WIDTH'(DELAY_CYCLES_3);
    endcase
  endfunction

  // Cycle count for a cool-down code; code 0 never starts the timer
  function automatic logic [TIMER_WIDTH-1:0] cooldown_cycles(input logic [1:0] code);
    case (code)
      2'h1: cooldown_cycles = TIMER_WIDTH'(COOLDOWN_CYCLES_1);
      2'h2: cooldown_cycles = TIMER_WIDTH'(COOLDOWN_CYCLES_2);
      default: cooldown_cycles = TIMER_WIDTH'(COOLDOWN_CYCLES_3);
    endcase
  endfunction

  // Field views of the stored configuration
  assign cooldown_select_ch2 = state.cfg[COOLDOWN_LSB +: 2];
  assign delayed_off_time_ch2 = state.cfg[DELAY_LSB +: 2];

  // Timer lengths from the stored codes; each timer copies its length on the
  // start pulse, so a write during a running timer only affects the next run
  // delay length
  assign delay_length = delay_cycles(delayed_off_time_ch2);
  assign cooldown_length = cooldown_cycles(cooldown_select_ch2);

  // Only a read at the result offset clears the flag
  // read clears flag
  assign result_read = reg_rd_i && (reg_addr_i == ADDR_VOLTAGE_RESULT);

  // Latest conversion and its freshness flag
  cwpr_result_capture u_capture (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_valid_i(adc_valid_i),
    .sample_i(adc_data_i),
    .read_i(result_read),
    .value_o(voltage_result_value_ch2),
    .fresh_o(voltage_result_fresh_ch2)
  );

  // Over-threshold persistence timer
  // Busy is not needed: the sequencer state already shows a running delay
  cwpr_timer u_delay_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(delay_start),
    .abort_i(delay_abort),
    .length_i(delay_length),
    .busy_o(),
    .done_o(delay_done)
  );

  // Retry wait timer
  // Never aborted: only the end of the wait leaves the cool-down state
  cwpr_timer u_cooldown_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(cooldown_start),
    .abort_i(1'b0),
    .length_i(cooldown_length),
    .busy_o(),
    .done_o(cooldown_done)
  );

  // Register access, protection sequencer and decoded levels
  always_comb
  begin
    next_state = state;
    delay_start = 1'b0;
    delay_abort = 1'b0;
    cooldown_start = 1'b0;
    fault = 1'b0;

    if (reg_wr_i && (reg_addr_i == ADDR_PROTECT_CFG))
    begin
      next_state.cfg = reg_wdata_i & CFG_WRITE_MASK;
    end

    // Read data, unmapped offsets answer zero
    // A read in the cycle of a write returns the configuration as it was
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_VOLTAGE_RESULT:
        begin
          next_state.rdata = 16'h0000;
          next_state.rdata[RESULT_WIDTH-1:0] = voltage_result_value_ch2;
          next_state.rdata[FRESH_BIT] = voltage_result_fresh_ch2;
        end
        ADDR_PROTECT_CFG:
        begin
          next_state.rdata = state.cfg & CFG_WRITE_MASK;
        end
        default:
        begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end

    // Sequencer: on watches for overcurrent or an energy trip, delay times
    // how long the overcurrent lasts, cool-down waits before an automatic
    // retry and latched holds the channel off until restart_i; trip and
    // overcurrent inputs are ignored while the channel is forced off
    case (state.fsm)
      ST_ON:
      begin
        if (energy_trip_i)
        begin
          fault = 1'b1;
        end
        else if (over_threshold_i)
        begin
          next_state.fsm = ST_DELAY;
          delay_start = 1'b1;
        end
      end
      ST_DELAY:
      begin
        if (energy_trip_i || delay_done)
        begin
          fault = 1'b1;
          delay_abort = 1'b1;
        end
        else if (!over_threshold_i)
        begin
          next_state.fsm = ST_ON;
          delay_abort = 1'b1;
        end
      end
      ST_COOLDOWN:
      begin
        if (cooldown_done)
        begin
          next_state.fsm = ST_ON;
        end
      end
      ST_LATCHED:
      begin
        if (restart_i)
        begin
          next_state.fsm = ST_ON;
        end
      end
      default:
      begin
        // Unknown code recovers to on
        next_state.fsm = ST_ON;
      end
    endcase

    // Shutdown entry chooses latch or timed retry
    if (fault)
    begin
      if (cooldown_select_ch2 == COOLDOWN_LATCH)
      begin
        next_state.fsm = ST_LATCHED;
      end
      else
      begin
        next_state.fsm = ST_COOLDOWN;
        cooldown_start = 1'b1;
      end
    end

    // Forced-off flags follow the next state so they change with it
    next_state.shutdown = (next_state.fsm == ST_COOLDOWN) || (next_state.fsm == ST_LATCHED);
    next_state.latched = (next_state.fsm == ST_LATCHED);

    // Decoded levels change at the same edge as the configuration
    // threshold decode
    next_state.threshold = threshold_level(next_state.cfg[THRESHOLD_LSB +: 2]);
    next_state.trip = trip_level(next_state.cfg[TRIP_LSB +: 4]);
    next_state.nominal = nominal_level(next_state.cfg[NOMINAL_LSB +: 3]);
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state.cfg <= PROTECT_CFG_RESET;
      state.fsm <= ST_ON;
      state.rdata <= VOLTAGE_RESULT_RESET;
      state.shutdown <= 1'b0;
      state.latched <= 1'b0;
      // Code-zero levels
      state.threshold <= threshold_level(2'h0);
      state.trip <= trip_level(4'h0);
      state.nominal <= nominal_level(3'h0);
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from state
  assign reg_rdata_o = state.rdata;
  assign channel_shutdown_o = state.shutdown;
  assign latched_off_o = state.latched;
  assign delayed_off_threshold_ch2_o = state.threshold;
  assign energy_trip_level_ch2_o = state.trip;
  assign nominal_current_ch2_o = state.nominal;

endmodule

//--- dv/cwpr_regs_properties.sv
/*
  Concurrent checks on the ports of cwpr_regs.
  Assumes one clock domain and the bind at the foot of this file.
*/
module cwpr_regs_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Conversion and events
  input wire logic adc_valid_i,
  input wire logic [cwpr_pkg::RESULT_WIDTH-1:0] adc_data_i,
  input wire logic over_threshold_i,
  input wire logic energy_trip_i,
  input wire logic restart_i,
  // Outputs
  input wire logic channel_shutdown_o,
  input wire logic latched_off_o,
  input wire logic [15:0] delayed_off_threshold_ch2_o,
  input wire logic [11:0] energy_trip_level_ch2_o,
  input wire logic [7:0] nominal_current_ch2_o
);
  import cwpr_pkg::*;
  // Expected decode tables
  localparam logic [15:0] THR [4] = '{16'h07a3, 16'h06e0, 16'h0645, 16'h0532};
  localparam logic [11:0] TRP [16] = '{12'h058, 12'h083, 12'h107, 12'h18a, 12'h20d, 12'h290,
    12'h314, 12'h397, 12'h446, 12'h4f5, 12'h5a4, 12'h67f, 12'h785, 12'h88c, 12'ha41, 12'hdac};
  localparam logic [7:0] NOM [8] = '{8'h28, 8'h32, 8'h39, 8'h41, 8'h4b, 8'h5a, 8'h78, 8'h96};
  logic rd_v;
  logic wr_c;
  // Decoded accesses
  assign rd_v = reg_rd_i && (reg_addr_i == ADDR_VOLTAGE_RESULT);
  assign wr_c = reg_wr_i && (reg_addr_i == ADDR_PROTECT_CFG);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_VRES_TOP: assert property (rd_v |=> reg_rdata_o[15:11] == 5'h00)
    else $error("voltage result upper bits not zero");
  AST_FRESH_SET: assert property ((adc_valid_i && !reg_rd_i) ##1 (rd_v && !adc_valid_i)
    |=> reg_rdata_o[10:0] == {1'b1, $past(adc_data_i, 2)}) else $error("new result not flagged");
  AST_FRESH_CLR: assert property ((rd_v && !adc_valid_i) ##1 !adc_valid_i ##1 rd_v |=> !reg_rdata_o[10])
    else $error("flag not cleared by read");
  AST_CFG_RSV: assert property (reg_rd_i && reg_addr_i == ADDR_PROTECT_CFG |=> reg_rdata_o[13:11] == 3'h0)
    else $error("reserved config bits not zero");
  AST_THR: assert property (wr_c |=> delayed_off_threshold_ch2_o == THR[$past(reg_wdata_i[8:7])])
    else $error("threshold decode wrong");
  AST_TRIP: assert property (wr_c |=> energy_trip_level_ch2_o == TRP[$past(reg_wdata_i[6:3])])
    else $error("trip level decode wrong");
  AST_NOM: assert property (wr_c |=> nominal_current_ch2_o == NOM[$past(reg_wdata_i[2:0])])
    else $error("nominal current decode wrong");
  AST_LATCH_OFF: assert property (latched_off_o |-> channel_shutdown_o)
    else $error("latched without shutdown");
  AST_LATCH_HOLD: assert property (latched_off_o && !restart_i |=> latched_off_o)
    else $error("latch released without restart");
  AST_TRIP_OFF: assert property (energy_trip_i && !channel_shutdown_o |=> channel_shutdown_o)
    else $error("energy trip did not shut down");
  // Main scenarios seen
  cover property ($rose(latched_off_o));
  cover property ($fell(channel_shutdown_o));
  cover property (rd_v ##1 reg_rdata_o[10]);
endmodule

bind cwpr_regs cwpr_regs_properties u_cwpr_regs_properties (.clk_i(clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i),
  .over_threshold_i(over_threshold_i), .energy_trip_i(energy_trip_i), .restart_i(restart_i),
  .channel_shutdown_o(channel_shutdown_o), .latched_off_o(latched_off_o),
  .delayed_off_threshold_ch2_o(delayed_off_threshold_ch2_o),
  .energy_trip_level_ch2_o(energy_trip_level_ch2_o), .nominal_current_ch2_o(nominal_current_ch2_o));

//--- dv/cwpr_host_model.sv
/*
  Host side of the register port: one-cycle read and write strobes.
  Assumes tasks are called at a falling edge of clk_i.
*/
module cwpr_host_model (
  // Clock
  input wire logic clk_i,
  // Register port towards the device
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle port at time zero
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
    reg_rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(negedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
    @(negedge clk_i);
  endtask
  // One read; data is taken once the read edge has passed
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(negedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    d = reg_rdata_i;
    @(negedge clk_i);
  endtask
endmodule

//--- dv/test_cwpr_regs.sv
/*
  Self-checking bench for cwpr_regs with shortened cool-down times and delay codes 2 and 3.
  Assumes the host model and the bound property checker.
*/
module test_cwpr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import cwpr_pkg::*;
  localparam int D [4] = '{DELAY_CYCLES_0, DELAY_CYCLES_1, 8, 10};
  // Decoded levels per code
  localparam logic [15:0] T_THR [4] = '{16'h07a3, 16'h06e0, 16'h0645, 16'h0532};
  localparam logic [11:0] T_TRP [16] = '{12'h058, 12'h083, 12'h107, 12'h18a, 12'h20d, 12'h290,
    12'h314, 12'h397, 12'h446, 12'h4f5, 12'h5a4, 12'h67f, 12'h785, 12'h88c, 12'ha41, 12'hdac};
  localparam logic [7:0] T_NOM [8] = '{8'h28, 8'h32, 8'h39, 8'h41, 8'h4b, 8'h5a, 8'h78, 8'h96};
  localparam int C [4] = '{0, 20, 30, 40};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic adc_valid = 1'b0;
  logic [9:0] adc_data = 10'h000;
  logic over_thr = 1'b0;
  logic e_trip = 1'b0;
  logic restart = 1'b0;
  logic shut;
  logic latched;
  logic [15:0] thr;
  logic [11:0] trip;
  logic [7:0] nom;
  int err_count = 0;
  int comparisons = 0;
  // Clock, 100 ns period
  always #50 clk_i = ~clk_i;
  // Device and host
  cwpr_regs #(.DELAY_CYCLES_2(8), .DELAY_CYCLES_3(10),
    .COOLDOWN_CYCLES_1(20), .COOLDOWN_CYCLES_2(30), .COOLDOWN_CYCLES_3(40)) u_cwpr_regs (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .adc_valid_i(adc_valid), .adc_data_i(adc_data),
    .over_threshold_i(over_thr), .energy_trip_i(e_trip), .restart_i(restart),
    .channel_shutdown_o(shut), .latched_off_o(latched), .delayed_off_threshold_ch2_o(thr),
    .energy_trip_level_ch2_o(trip), .nominal_current_ch2_o(nom));
  cwpr_host_model u_cwpr_host_model (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata));
  // Compare and count
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", n, exp, seen);
      err_count++;
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One conversion strobe
  task automatic pulse_adc(input logic [9:0] v);
    adc_valid <= 1'b1;
    adc_data <= v;
    @(negedge clk_i);
    adc_valid <= 1'b0;
    adc_data <= ~v;
  endtask
  // Cool-down length and release; shutdown stands for exactly C cycles
  task automatic cool(input int i);
    repeat (C[i] - 1) @(negedge clk_i);
    check("shut held", 16'(shut), 16'h0001);
    @(negedge clk_i);
    check("shut end", 16'(shut), 16'h0000);
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    logic [15:0] d;
    logic [3:0] c;
    logic [15:0] w;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    check("thr rst", thr, 16'h07a3);
    check("trip rst", 16'(trip), 16'h0058);
    check("nom rst", 16'(nom), 16'h0028);
    u_cwpr_host_model.rd(ADDR_PROTECT_CFG, d);
    check("cfg rst", d, 16'h0000);
    u_cwpr_host_model.rd(ADDR_VOLTAGE_RESULT, d);
    check("vres rst", d, 16'h0000);
    $display("reset test done");
    u_cwpr_host_model.wr(ADDR_PROTECT_CFG, 16'hffff);
    u_cwpr_host_model.rd(ADDR_PROTECT_CFG, d);
    check("cfg mask", d, 16'hc7ff);
    check("nom max", 16'(nom), 16'h0096);
    u_cwpr_host_model.wr(ADDR_VOLTAGE_RESULT, 16'hffff);
    u_cwpr_host_model.rd(ADDR_VOLTAGE_RESULT, d);
    check("vres ro", d, 16'h0000);
    u_cwpr_host_model.rd(8'h1d, d);
    check("unmapped", d, 16'h0000);
    for (int k = 0; k < 16; k++)
    begin
      c = 4'(k);
      w = {c[1:0], 3'h0, c[1:0], c[1:0], c, c[2:0]};
      u_cwpr_host_model.wr(ADDR_PROTECT_CFG, w);
      check("thr code", thr, T_THR[c[1:0]]);
      check("trip code", 16'(trip), 16'(T_TRP[c]));
      check("nom code", 16'(nom), 16'(T_NOM[c[2:0]]));
      u_cwpr_host_model.rd(ADDR_PROTECT_CFG, d);
      check("cfg code", d, w);
    end
    $display("register test done");
    pulse_adc(10'h2a5);
    u_cwpr_host_model.rd(ADDR_VOLTAGE_RESULT, d);
    check("vres new", d, 16'h06a5);
    u_cwpr_host_model.rd(ADDR_VOLTAGE_RESULT, d);
    check("vres old", d, 16'h02a5);
    fork
      u_cwpr_host_model.rd(ADDR_VOLTAGE_RESULT, d);
      pulse_adc(10'h3ff);
    join
    check("vres same cycle", d, 16'h02a5);
    u_cwpr_host_model.rd(ADDR_VOLTAGE_RESULT, d);
    check("vres set wins", d, 16'h07ff);
    $display("conversion test done");
    for (int i = 0; i < 4; i++)
    begin
      c = 4'(i);
      u_cwpr_host_model.wr(ADDR_PROTECT_CFG, {c[1:0], 3'h0, c[1:0], 9'h000});
      over_thr <= 1'b1;
      repeat (D[i]) @(negedge clk_i);
      check("shut early", 16'(shut), 16'h0000);
      @(negedge clk_i);
      check("shut on time", 16'(shut), 16'h0001);
      check("latched", 16'(latched), 16'(i == 0));
      over_thr <= 1'b0;
      if (i == 0)
      begin
        repeat (50) @(negedge clk_i);
        check("no retry", 16'(shut), 16'h0001);
        restart <= 1'b1;
        @(negedge clk_i);
        restart <= 1'b0;
        @(negedge clk_i);
        check("restart", 16'(shut), 16'h0000);
        check("unlatched", 16'(latched), 16'h0000);
      end
      else
        cool(i);
    end
    over_thr <= 1'b1;
    repeat (D[3] - 2) @(negedge clk_i);
    over_thr <= 1'b0;
    repeat (12) @(negedge clk_i);
    check("short overload", 16'(shut), 16'h0000);
    u_cwpr_host_model.wr(ADDR_PROTECT_CFG, 16'h4000);
    e_trip <= 1'b1;
    @(negedge clk_i);
    e_trip <= 1'b0;
    check("trip off", 16'(shut), 16'h0001);
    cool(1);
    $display("protection test done");
    complete_run();
  end
endmodule
